// >>> design/rotate_subtract_return_exec.sv
// Purpose: Executes rotate through carry, subtract with borrow and subroutine return.
// Assumes: One instruction cycle is two clocks; fetch and decode sit outside.
// Notes:   The operand read is registered, so each instruction cycle spans two clocks.
// Function
// - Rotate left: bits 6..0 move up, carry enters bit 0, bit 7 becomes carry.
// - Rotate right: bits 7..1 move down, carry enters bit 7, bit 0 becomes carry.
// - Rotates and file subtract: destination 0 writes working register, 1 file register.
// - Return loads program counter from stack top in two cycles, flags untouched.
// - Return pops the call stack, depth drops by one unless it is already zero.
// - File subtract: file register plus inverted working register plus carry, flags updated.
// - Immediate subtract: immediate + ~working register + carry, into working register.
// - A borrow clears the carry flag.
// - A zero result without borrow sets zero and carry.
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_return_exec (
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  input  wire logic                                i_valid,
  input  wire logic [2:0]                          i_op,
  input  wire logic [rsr_pkg::ADDR_W-1:0]          i_addr,
  input  wire logic                                i_dest,
  input  wire logic [rsr_pkg::DATA_W-1:0]          i_imm,
  input  wire logic                                i_load_en,
  input  wire logic [rsr_pkg::ADDR_W-1:0]          i_load_addr,
  input  wire logic [rsr_pkg::DATA_W-1:0]          i_load_data,
  input  wire logic                                i_preset_en,
  input  wire logic [rsr_pkg::DATA_W-1:0]          i_preset_acc,
  input  wire logic                                i_preset_carry,
  input  wire logic                                i_stack_push,
  input  wire logic [rsr_pkg::PC_W-1:0]            i_stack_top,
  output logic                                     o_ready,
  output logic                                     o_done,
  output logic [rsr_pkg::DATA_W-1:0]               o_working_register,
  output logic                                     o_carry,
  output logic                                     o_zero,
  output logic                                     o_half_carry_flag,
  output logic [rsr_pkg::PC_W-1:0]                 o_pc,
  output logic [rsr_pkg::DEPTH_W-1:0]              o_stack_depth,
  output logic                                     o_stack_pop
);

  typedef struct packed {
    rsr_pkg::state_t                 st;
    logic [1:0]                      cnt;
    rsr_pkg::op_t                    op;
    logic                            dest;
    logic [rsr_pkg::ADDR_W-1:0]      addr;
    logic [rsr_pkg::DATA_W-1:0]      imm;
    logic [rsr_pkg::DATA_W-1:0]      acc;
    logic                            carry;
    logic                            zero;
    logic                            half;
    logic [rsr_pkg::PC_W-1:0]        pc;
    logic [rsr_pkg::DEPTH_W-1:0]     depth;
    logic                            ready;
    logic                            done;
    logic                            pop;
  } core_t;

  localparam core_t CORE_RST = '{
    st: rsr_pkg::ST_IDLE, cnt: 2'h0, op: rsr_pkg::OP_ROTATE_LEFT_VIA_CARRY,
    dest: 1'b0, addr: '0, imm: 8'h00, acc: rsr_pkg::ACC_RST, carry: 1'b0,
    zero: 1'b0, half: 1'b0, pc: rsr_pkg::PC_RST, depth: rsr_pkg::DEPTH_RST,
    ready: 1'b1, done: 1'b0, pop: 1'b0
  };

  // Codes outside the five known operations are never accepted.
  function automatic logic op_known(input logic [2:0] code);
    op_known = code <= 3'(rsr_pkg::OP_SUBROUTINE_RETURN);
  endfunction

  // Shared adder: a + ~w + c, with the half carry taken out of the low nibble.
  function automatic logic [rsr_pkg::DATA_W+1:0] sub_borrow(
    input logic [rsr_pkg::DATA_W-1:0] a,
    input logic [rsr_pkg::DATA_W-1:0] w,
    input logic                       c);
    logic [rsr_pkg::DATA_W:0]     full;
    logic [rsr_pkg::NIBBLE_W:0]   low;
    full = {1'b0, a} + {1'b0, ~w} + {8'h00, c};
    low  = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + {4'h0, c};
    sub_borrow = {low[rsr_pkg::NIBBLE_W], full};
  endfunction

  core_t      core_reg;
  core_t      core_next;
  file_reg_if fr ();

  logic [rsr_pkg::DATA_W-1:0]   result;
  logic [rsr_pkg::DATA_W+1:0]   arith;
  logic [rsr_pkg::DATA_W-1:0]   sub_a;
  logic                         new_carry;
  logic                         is_sub;
  logic                         exec_now;
  logic                         accept;

  file_reg_mem u_file_reg_mem (
    .i_clk (i_clk),
    .bus   (fr.mem)
  );

  assign accept   = core_reg.ready && i_valid && op_known(i_op);
  assign exec_now = core_reg.st == rsr_pkg::ST_EXEC;
  assign is_sub   = core_reg.op == rsr_pkg::OP_SUB_BORROW_FILE_REG ||
                    core_reg.op == rsr_pkg::OP_SUB_BORROW_IMMEDIATE;

  // The operand is read while the instruction is taken, so it is ready one clock later.
  assign fr.rd_addr = i_addr;
  assign sub_a      = (core_reg.op == rsr_pkg::OP_SUB_BORROW_IMMEDIATE) ?
                      core_reg.imm : fr.rd_data;
  assign arith      = sub_borrow(sub_a, core_reg.acc, core_reg.carry);

  always_comb begin
    result    = arith[rsr_pkg::DATA_W-1:0];
    new_carry = arith[rsr_pkg::DATA_W];
    unique case (core_reg.op)
      rsr_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        result    = {fr.rd_data[6:0], core_reg.carry};
        new_carry = fr.rd_data[rsr_pkg::BIT_MSB];
      end
      rsr_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        result    = {core_reg.carry, fr.rd_data[7:1]};
        new_carry = fr.rd_data[rsr_pkg::BIT_LSB];
      end
      rsr_pkg::OP_SUB_BORROW_FILE_REG,
      rsr_pkg::OP_SUB_BORROW_IMMEDIATE,
      rsr_pkg::OP_SUBROUTINE_RETURN: begin
      end
    endcase
  end

  // Direct loads share the write port; an executing write takes precedence.
  always_comb begin
    fr.wr_en   = i_load_en;
    fr.wr_addr = i_load_addr;
    fr.wr_data = i_load_data;
    if (exec_now && core_reg.dest && core_reg.op != rsr_pkg::OP_SUB_BORROW_IMMEDIATE) begin
      fr.wr_en   = 1'b1;
      fr.wr_addr = core_reg.addr;
      fr.wr_data = result;
    end
  end

  always_comb begin
    core_next      = core_reg;
    core_next.done = 1'b0;
    core_next.pop  = 1'b0;
    if (i_stack_push && core_reg.depth < rsr_pkg::DEPTH_W'(rsr_pkg::STACK_LEVELS)) begin
      core_next.depth = core_reg.depth + 4'h1;
    end
    unique case (core_reg.st)
      rsr_pkg::ST_IDLE: begin
        if (i_preset_en) begin
          core_next.acc   = i_preset_acc;
          core_next.carry = i_preset_carry;
        end
        if (accept) begin
          core_next.op    = rsr_pkg::op_t'(i_op);
          core_next.dest  = i_dest;
          core_next.addr  = i_addr;
          core_next.imm   = i_imm;
          core_next.ready = 1'b0;
          if (rsr_pkg::op_t'(i_op) == rsr_pkg::OP_SUBROUTINE_RETURN) begin
            core_next.st  = rsr_pkg::ST_RET;
            core_next.cnt = rsr_pkg::RET_WAIT;
          end else begin
            core_next.st  = rsr_pkg::ST_EXEC;
          end
        end
      end
      rsr_pkg::ST_EXEC: begin
        core_next.st    = rsr_pkg::ST_IDLE;
        core_next.ready = 1'b1;
        core_next.done  = 1'b1;
        core_next.carry = new_carry;
        if (!core_reg.dest || core_reg.op == rsr_pkg::OP_SUB_BORROW_IMMEDIATE) begin
          core_next.acc = result;
        end
        if (is_sub) begin
          core_next.zero = result == 8'h00;
          core_next.half = arith[rsr_pkg::DATA_W+1];
        end
      end
      rsr_pkg::ST_RET: begin
        if (core_reg.cnt == 2'h0) begin
          core_next.st    = rsr_pkg::ST_IDLE;
          core_next.ready = 1'b1;
          core_next.done  = 1'b1;
          core_next.pc    = i_stack_top;
          core_next.pop   = 1'b1;
          // An empty stack does not wrap and keeps a push in this clock; otherwise that push is lost.
          if (core_reg.depth != rsr_pkg::DEPTH_RST) begin
            core_next.depth = core_reg.depth - 4'h1;
          end
        end else begin
          core_next.cnt = core_reg.cnt - 2'h1;
        end
      end
      default: begin
        core_next = CORE_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_reg <= CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_ready            = core_reg.ready;
  assign o_done             = core_reg.done;
  assign o_working_register = core_reg.acc;
  assign o_carry            = core_reg.carry;
  assign o_zero             = core_reg.zero;
  assign o_half_carry_flag  = core_reg.half;
  assign o_pc               = core_reg.pc;
  assign o_stack_depth      = core_reg.depth;
  assign o_stack_pop        = core_reg.pop;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  rot_left_a: assert property (
    exec_now && core_reg.op == rsr_pkg::OP_ROTATE_LEFT_VIA_CARRY |=>
    o_carry == $past(fr.rd_data[7]) &&
    (o_working_register[0] == $past(o_carry) || $past(core_reg.dest)))
    else $error("rotate left carry wrong");
  rot_right_a: assert property (
    exec_now && core_reg.op == rsr_pkg::OP_ROTATE_RIGHT_VIA_CARRY && !core_reg.dest |=>
    o_carry == $past(fr.rd_data[0]) && o_working_register[7] == $past(o_carry))
    else $error("rotate right result wrong");
  dest_file_a: assert property (
    exec_now && core_reg.dest && core_reg.op != rsr_pkg::OP_SUB_BORROW_IMMEDIATE |->
    fr.wr_en && fr.wr_addr == core_reg.addr ##1 $stable(o_working_register))
    else $error("file destination not honoured");
  // A preset in the taking clock may still move the carry flag one clock later.
  ret_timing_a: assert property (
    accept && i_op == 3'h4 |=> !o_ready ##1
    (!o_ready && $stable(o_carry) && $stable(o_zero) && $stable(o_half_carry_flag))[*2] ##1
    o_ready && o_stack_pop && o_pc == $past(i_stack_top) && $stable(o_carry) &&
    $stable(o_zero) && $stable(o_half_carry_flag))
    else $error("return timing wrong");
  ret_pop_a: assert property (
    o_stack_pop && $past(o_stack_depth) != 4'h0 |->
    o_stack_depth == $past(o_stack_depth) - 4'h1)
    else $error("stack not popped");
  // Carry and zero are recomputed here from the operands, independent of the shared adder.
  sub_carry_a: assert property (
    exec_now && is_sub |=>
    o_carry == $past({1'b0, sub_a} + {1'b0, ~core_reg.acc} + 9'(core_reg.carry) > 9'h0ff) &&
    o_zero == $past(8'(sub_a + ~core_reg.acc + 8'(core_reg.carry)) == 8'h00))
    else $error("subtract flags wrong");
  sub_imm_a: assert property (
    exec_now && core_reg.op == rsr_pkg::OP_SUB_BORROW_IMMEDIATE |->
    (!fr.wr_en || fr.wr_addr == i_load_addr) ##1
    o_working_register == $past(core_reg.imm + ~core_reg.acc + 8'(core_reg.carry)))
    else $error("immediate subtract wrong");
  zero_pair_a: assert property (
    exec_now && is_sub &&
    {1'b0, sub_a} + {1'b0, ~core_reg.acc} + 9'(core_reg.carry) == 9'h100 |=>
    o_zero && o_carry)
    else $error("zero without borrow wrong");
  one_cycle_a: assert property (
    accept && i_op != 3'h4 |=> !o_ready ##1 o_ready && o_done)
    else $error("instruction cycle length wrong");

  cover_ret_c: cover property (accept && i_op == 3'h4 ##4 o_stack_pop);
  cover_borrow_c: cover property (exec_now && is_sub && !arith[8]);
  cover_zero_c: cover property (exec_now && is_sub && result == 8'h00 && arith[8]);
  cover_back_c: cover property (o_done && accept);

endmodule
`default_nettype wire

// >>> pkg/rsr_pkg.sv
// Purpose: Shared constants and types for the rotate, subtract and return execution block.
// Assumes: One 50 MHz core clock; one instruction cycle spans two clocks.
// Notes:   File register read data come out of a register, hence the two-clock cycle.
package rsr_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned PC_W           = 11;
  localparam int unsigned DEPTH_W        = 4;
  localparam int unsigned FILE_REGS      = 128;
  localparam int unsigned STACK_LEVELS   = 8;
  localparam int unsigned CLK_PER_ICYCLE = 2;
  localparam int unsigned RET_ICYCLES    = 2;
  localparam int unsigned RET_CLOCKS     = RET_ICYCLES * CLK_PER_ICYCLE;

  localparam int unsigned BIT_MSB        = 7;
  localparam int unsigned BIT_LSB        = 0;
  localparam int unsigned NIBBLE_W       = 4;

  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 11'h000;
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 4'h0;
  localparam logic [1:0]         RET_WAIT  = 2'(RET_CLOCKS - 2);

  typedef enum logic [2:0] {
    OP_ROTATE_LEFT_VIA_CARRY  = 3'h0,
    OP_ROTATE_RIGHT_VIA_CARRY = 3'h1,
    OP_SUB_BORROW_FILE_REG    = 3'h2,
    OP_SUB_BORROW_IMMEDIATE   = 3'h3,
    OP_SUBROUTINE_RETURN      = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RET  = 2'b11
  } state_t;

endpackage

// >>> pkg/file_reg_if.sv
// Purpose: Carrier between the execution block and its file register memory.
// Assumes: Read data appear one clock after the address is presented.
// Notes:   A write and a read of the same word in one clock return the old word.
`timescale 1ns/1ps
`default_nettype none
interface file_reg_if;
  logic [rsr_pkg::ADDR_W-1:0] rd_addr;
  logic [rsr_pkg::DATA_W-1:0] rd_data;
  logic                       wr_en;
  logic [rsr_pkg::ADDR_W-1:0] wr_addr;
  logic [rsr_pkg::DATA_W-1:0] wr_data;
  modport mem  (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
  modport user (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
endinterface
`default_nettype wire

// >>> design/file_reg_mem.sv
// Purpose: The 128 file registers, one write port and one registered read port.
// Assumes: Single clock; contents are undefined until written.
// Notes:   No reset on the array so that it maps onto plain memory.
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem (
  input  wire logic i_clk,
  file_reg_if.mem   bus
);
  logic [rsr_pkg::DATA_W-1:0] mem_array [rsr_pkg::FILE_REGS];

  always_ff @(posedge i_clk) begin
    if (bus.wr_en) begin
      mem_array[bus.wr_addr] <= bus.wr_data;
    end
    bus.rd_data <= mem_array[bus.rd_addr];
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the rotate, subtract and return execution block.
// Assumes: Inputs change 1 ns after the rising edge; completion is awaited with a bounded count.
// Notes:   File registers are read back by a subtract of 0xff with carry clear into the
//          working register, because the block has no direct read port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_valid = 1'b0;
  logic [2:0]  i_op = 3'h0;
  logic [6:0]  i_addr = 7'h00;
  logic        i_dest = 1'b0;
  logic [7:0]  i_imm = 8'h00;
  logic        i_load_en = 1'b0;
  logic [6:0]  i_load_addr = 7'h00;
  logic [7:0]  i_load_data = 8'h00;
  logic        i_preset_en = 1'b0;
  logic [7:0]  i_preset_acc = 8'h00;
  logic        i_preset_carry = 1'b0;
  logic        i_stack_push = 1'b0;
  logic [10:0] i_stack_top = 11'h000;
  logic        o_ready;
  logic        o_done;
  logic [7:0]  o_working_register;
  logic        o_carry;
  logic        o_zero;
  logic        o_half_carry_flag;
  logic [10:0] o_pc;
  logic [3:0]  o_stack_depth;
  logic        o_stack_pop;
  int          n_mismatch = 0;
  int          n_tests = 0;

  rotate_subtract_return_exec uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid), .i_op(i_op),
    .i_addr(i_addr), .i_dest(i_dest), .i_imm(i_imm), .i_load_en(i_load_en),
    .i_load_addr(i_load_addr), .i_load_data(i_load_data), .i_preset_en(i_preset_en),
    .i_preset_acc(i_preset_acc), .i_preset_carry(i_preset_carry),
    .i_stack_push(i_stack_push), .i_stack_top(i_stack_top), .o_ready(o_ready),
    .o_done(o_done), .o_working_register(o_working_register), .o_carry(o_carry),
    .o_zero(o_zero), .o_half_carry_flag(o_half_carry_flag), .o_pc(o_pc),
    .o_stack_depth(o_stack_depth), .o_stack_pop(o_stack_pop));

  always #(rsr_pkg::CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called at 1 ns after an edge while idle, so back-to-back calls hit the done cycle.
  task automatic exec(input logic [2:0] op, input logic [6:0] a, input logic d,
                      input logic [7:0] imm, input int clocks);
    int cnt;
    i_valid = 1'b1;
    i_op = op;
    i_addr = a;
    i_dest = d;
    i_imm = imm;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    cnt = 1;
    while (o_done !== 1'b1 && cnt < 10) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    check("done latency", 11'(clocks), 11'(cnt));
  endtask

  task automatic load(input logic [6:0] a, input logic [7:0] v);
    i_load_en = 1'b1;
    i_load_addr = a;
    i_load_data = v;
    @(posedge i_clk);
    #1;
    i_load_en = 1'b0;
  endtask

  task automatic preset(input logic [7:0] acc, input logic c);
    i_preset_en = 1'b1;
    i_preset_acc = acc;
    i_preset_carry = c;
    @(posedge i_clk);
    #1;
    i_preset_en = 1'b0;
  endtask

  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    preset(8'hff, 1'b0);
    exec(3'h2, a, 1'b0, 8'h00, 2);
    check("file reg", 11'(exp), 11'(o_working_register));
  endtask

  task automatic test_reset;
    check("ready", 11'h001, 11'(o_ready));
    check("acc", 11'h000, 11'(o_working_register));
    check("flags", 11'h000, 11'({o_carry, o_zero, o_half_carry_flag, o_stack_pop}));
    check("pc depth", 11'h000, o_pc | 11'(o_stack_depth));
  endtask

  task automatic sub_case(input logic imm_form, input logic [7:0] a, input logic [7:0] w,
                          input logic c);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, ~w} + 9'(c);
    low = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
    if (!imm_form) begin
      load(7'h7f, a);
    end
    preset(w, c);
    // The top address proves the full 7-bit field reaches the memory.
    exec(imm_form ? 3'h3 : 3'h2, 7'h7f, 1'b1, a, 2);
    check("carry", 11'(sum[8]), 11'(o_carry));
    check("zero", 11'(sum[7:0] == 8'h00), 11'(o_zero));
    check("half carry", 11'(low[4]), 11'(o_half_carry_flag));
    if (imm_form) begin
      check("acc", 11'(sum[7:0]), 11'(o_working_register));
    end else begin
      check("acc kept", 11'(w), 11'(o_working_register));
      peek(7'h7f, sum[7:0]);
    end
  endtask

  task automatic test_rotate;
    load(7'h05, 8'ha5);
    preset(8'h05, 1'b0);
    exec(3'h3, 7'h00, 1'b0, 8'h06, 2);
    preset(8'h33, 1'b0);
    exec(3'h0, 7'h05, 1'b1, 8'h00, 2);
    check("rotl carry", 11'h001, 11'(o_carry));
    check("rotl z dc", 11'h003, 11'({o_zero, o_half_carry_flag}));
    check("rotl acc", 11'h033, 11'(o_working_register));
    peek(7'h05, 8'h4a);
    load(7'h05, 8'ha5);
    preset(8'h33, 1'b0);
    exec(3'h1, 7'h05, 1'b0, 8'h00, 2);
    check("rotr carry", 11'h001, 11'(o_carry));
    check("rotr acc", 11'h052, 11'(o_working_register));
    peek(7'h05, 8'ha5);
  endtask

  // An unknown operation code must leave the block idle and the working register untouched.
  task automatic test_refused;
    logic [7:0] acc;
    acc = o_working_register;
    i_valid = 1'b1;
    i_op = 3'h5;
    i_imm = 8'h3c;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    check("refused ready", 11'h001, 11'(o_ready));
    @(posedge i_clk);
    #1;
    check("refused done", 11'h000, 11'(o_done));
    check("refused acc", 11'(acc), 11'(o_working_register));
  endtask

  task automatic test_return;
    logic [1:0] zh;
    for (int k = 0; k < 2; k++) begin
      i_stack_push = 1'b1;
      @(posedge i_clk);
      #1;
      i_stack_push = 1'b0;
      @(posedge i_clk);
      #1;
    end
    preset(8'h00, 1'b1);
    zh = {o_zero, o_half_carry_flag};
    i_stack_top = 11'h5a3;
    exec(3'h4, 7'h00, 1'b0, 8'h00, 4);
    check("pc", 11'h5a3, o_pc);
    check("pop", 11'h001, 11'(o_stack_pop));
    check("depth", 11'h001, 11'(o_stack_depth));
    check("ret flags", 11'({1'b1, zh}), 11'({o_carry, o_zero, o_half_carry_flag}));
    exec(3'h4, 7'h00, 1'b0, 8'h00, 4);
    exec(3'h4, 7'h00, 1'b0, 8'h00, 4);
    check("empty depth", 11'h000, 11'(o_stack_depth));
  endtask

  initial begin
    #(rsr_pkg::CLK_PERIOD_NS * 3000);
    n_mismatch++;
    summarize;
  end

  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    test_reset;
    for (int f = 0; f < 2; f++) begin
      sub_case(f[0], 8'h05, 8'h06, 1'b0);
      sub_case(f[0], 8'h05, 8'h06, 1'b1);
      sub_case(f[0], 8'h06, 8'h05, 1'b0);
      sub_case(f[0], 8'h06, 8'h05, 1'b1);
    end
    test_rotate;
    test_refused;
    test_return;
    summarize;
  end
endmodule
`default_nettype wire
